// [src/bss_pkg.sv]
/*
 * Package for the buck startup and fault sequencer: state codes, phase
 * times and their cycle counts, short-circuit threshold codes.
 * Assumes a 125 MHz sequencer clock.
 */
package bss_pkg;
   // Clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 8000;
   // Phase times in microseconds, as specified
   localparam int unsigned SAMPLE_TIME_US = 1000;
   localparam int unsigned PRECOND_TIME_US = 1000;
   localparam int unsigned HICCUP_TIME_US = 50000;
   // Cycle counts derived from the times (exact at 8 ns)
   localparam int unsigned SAMPLE_CYCLES = (SAMPLE_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned PRECOND_CYCLES = (PRECOND_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned HICCUP_CYCLES = (HICCUP_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
   // Width of the shared phase timer
   localparam int unsigned TIMER_W = 23;
   // Fault counter width and full count
   localparam int unsigned FCNT_W = 3;
   localparam logic [2:0] FCNT_FULL = 3'h7;
   localparam logic [2:0] FCNT_ZERO = 3'h0;
   // Input synchroniser depth
   localparam int unsigned SYNC_STAGES = 2;
   // Short-circuit threshold selection codes
   localparam logic [1:0] SCP_100MV = 2'h0;
   localparam logic [1:0] SCP_200MV = 2'h1;
   localparam logic [1:0] SCP_280MV = 2'h2;
   // Value of the threshold select after reset
   localparam logic [1:0] SCP_RESET = 2'h1;

   // Sequencer states
   typedef enum logic [2:0] {
      BSS_OFF,
      BSS_SAMPLE,
      BSS_PRECOND,
      BSS_SOFTSTART,
      BSS_RUN,
      BSS_HICCUP,
      BSS_THERMAL
   } bss_state_t;
endpackage : bss_pkg

// [src/bss_sync.sv]
/*
 * Bank of two-flip-flop synchronisers for asynchronous comparator inputs.
 * Assumes each bit is a static level or slow relative to the clock.
 */
`timescale 1ns/1ps
module bss_sync #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [WIDTH-1:0] i_async,
   input wire logic [WIDTH-1:0] i_reset_val,
   output logic [WIDTH-1:0] o_sync
);
   // State: first and second stage of every bit, plus the fill count after reset
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [1:0] fill;
   } bss_sync_t;

   bss_sync_t sync_reg;
   bss_sync_t sync_next;
   logic [WIDTH-1:0] meta_d; // Next value of stage one, per bit
   logic [WIDTH-1:0] sync_d; // Next value of stage two, per bit

   // Each bit gets its own two stages; only stage two is read outside
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         assign meta_d[g] = i_async[g];
         assign sync_d[g] = sync_reg.meta[g];
      end
   endgenerate

   // Next state: shift both stages, count the fill up to two and stop there
   always_comb begin
      sync_next = sync_reg;
      sync_next.meta = meta_d;
      sync_next.sync = sync_d;
      if (sync_reg.fill != 2'h2) begin
         sync_next.fill = sync_reg.fill + 2'h1;
      end
   end

   // Registers settle to zero; reset values are applied by the output mux
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   // Output stays at the caller's chosen safe value until the pipe has filled
   assign o_sync = (sync_reg.fill == 2'h2) ? sync_reg.sync : i_reset_val;
endmodule : bss_sync

// [src/bss_sequencer.sv]
/*
 * Startup, hiccup and thermal sequencer of a synchronous buck controller.
 * Assumes comparator results arrive asynchronously from analog circuits and
 * that i_rst_b is released by the oscillator domain at power-on.
 */
// Contract
// - Undervoltage keeps both gate drives off.
// - Start only with supply good and enabled.
// - Disable enters shutdown, regulator off.
// - Undriven enable counts as asserted.
// - Sample compensation pin for one millisecond.
// - Latch one of three short-circuit thresholds.
// - Then hold compensation low one millisecond.
// - Soft-start only after both phases, except hiccup restart, which runs precondition only, and thermal restart, which enters soft-start directly.
// - Overcurrent cycle increments fault counter.
// - High-side overcurrent ends on-time early.
// - Clean cycle decrements fault counter.
// - Full count turns both drives off.
// - Wait fifty milliseconds, restart, repeat.
// - Power good low on listed conditions.
// - Thermal shutdown drives off, restarts via soft-start.
`timescale 1ns/1ps
module bss_sequencer #(
   parameter int unsigned SAMPLE_CYC = bss_pkg::SAMPLE_CYCLES,
   parameter int unsigned PRECOND_CYC = bss_pkg::PRECOND_CYCLES,
   parameter int unsigned HICCUP_CYC = bss_pkg::HICCUP_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_supply_ok,          // Input above lockout level
   input wire logic i_enable_oe_b,        // Enable pin driven by the outside (low = driven)
   input wire logic i_enable_level,       // Enable pin level when driven
   input wire logic i_regulator_ok,       // Internal regulator output is up
   input wire logic i_over_temp,          // Die over thermal limit (with hysteresis)
   input wire logic i_comp_cur_high,      // Sampled comp current above upper limit
   input wire logic i_comp_cur_low,       // Sampled comp current above lower limit
   input wire logic i_cycle_start,        // Oscillator cycle boundary, same clock
   input wire logic i_pwm_high,           // Modulator asks for high-side on, same clock
   input wire logic i_hs_over,            // High-side drop above threshold
   input wire logic i_ls_over,            // Low-side drop above selected threshold
   input wire logic i_softstart_done,     // Soft-start ramp has finished
   input wire logic i_fb_in_window,       // Feedback input within regulation window
   output logic o_regulator_en,           // Internal regulator enable
   output logic o_osc_en,                 // Oscillator enable
   output logic o_comp_sample,            // Drive fixed level on compensation pin
   output logic o_comp_pull_low,          // Hold compensation pin low
   output logic o_softstart_en,           // Soft-start ramp running
   output logic [1:0] o_scp_select,       // Latched short-circuit threshold code
   output logic o_high_side_gate_drive,   // High-side gate drive
   output logic o_low_side_gate_drive,    // Low-side gate drive
   output logic o_power_ok_output_oe_b,   // Power-ok pull-down enable, low = pulling low
   output logic [2:0] o_fault_count,      // Fault counter
   output logic o_fault                   // Hiccup fault declared
);
   // Pin-side inputs gathered into one synchroniser bank
   localparam int unsigned NSYNC = 10;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] safe_in;
   logic [NSYNC-1:0] syn;

   assign raw_in = {i_supply_ok, i_enable_oe_b, i_enable_level, i_regulator_ok, i_over_temp,
                    i_comp_cur_high, i_comp_cur_low, i_hs_over, i_ls_over, i_fb_in_window};
   // Safe values until synchronised: undervoltage, over temperature assumed
   assign safe_in = 10'h020;

   bss_sync #(
      .WIDTH(NSYNC)
   ) u_sync (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_async(raw_in),
      .i_reset_val(safe_in),
      .o_sync(syn)
   );

   logic s_supply_ok;
   logic s_en_undriven;
   logic s_en_level;
   logic s_reg_ok;
   logic s_hot;
   logic s_cur_high;
   logic s_cur_low;
   logic s_hs_over;
   logic s_ls_over;
   logic s_fb_ok;
   assign {s_supply_ok, s_en_undriven, s_en_level, s_reg_ok, s_hot,
           s_cur_high, s_cur_low, s_hs_over, s_ls_over, s_fb_ok} = syn;

   // Floating enable reads as asserted, like a weak pull-up
   logic enabled;
   assign enabled = s_en_undriven | s_en_level;
   logic run_ok;
   assign run_ok = s_supply_ok & enabled;

   // All sequencer state in one struct
   typedef struct packed {
      bss_pkg::bss_state_t state;
      logic [bss_pkg::TIMER_W-1:0] timer;
      logic [1:0] scp;
      logic [2:0] fcnt;
      logic hs_over_seen;      // High-side overcurrent seen this cycle
      logic ls_over_seen;      // Low-side overcurrent seen this cycle
      logic hs_cut;            // High-side on-time terminated this cycle
   } bss_seq_t;

   bss_seq_t seq_reg;
   bss_seq_t seq_next;

   localparam logic [bss_pkg::TIMER_W-1:0] T_SAMPLE = bss_pkg::TIMER_W'(SAMPLE_CYC - 1);
   localparam logic [bss_pkg::TIMER_W-1:0] T_PRECOND = bss_pkg::TIMER_W'(PRECOND_CYC - 1);
   localparam logic [bss_pkg::TIMER_W-1:0] T_HICCUP = bss_pkg::TIMER_W'(HICCUP_CYC - 1);

   logic switching;
   logic over_now;
   assign switching = (seq_reg.state == bss_pkg::BSS_SOFTSTART) ||
                      (seq_reg.state == bss_pkg::BSS_RUN);
   assign over_now = seq_reg.hs_over_seen | seq_reg.ls_over_seen;

   // Next-state logic: sequencing, threshold latch, fault counter
   always_comb begin
      seq_next = seq_reg;
      seq_next.timer = seq_reg.timer + 1'b1;
      // Overcurrent flags accumulate within a switching cycle
      if (switching) begin
         if (s_hs_over) begin
            seq_next.hs_over_seen = 1'b1;
            seq_next.hs_cut = 1'b1;
         end
         if (s_ls_over) begin
            seq_next.ls_over_seen = 1'b1;
         end
      end
      // Cycle boundary: count the closed cycle, then clear flags
      if (switching && i_cycle_start) begin
         if (over_now) begin
            if (seq_reg.fcnt != bss_pkg::FCNT_FULL) begin
               seq_next.fcnt = seq_reg.fcnt + 3'h1;
            end
         end else if (seq_reg.fcnt != bss_pkg::FCNT_ZERO) begin
            seq_next.fcnt = seq_reg.fcnt - 3'h1;
         end
         // A new event in the boundary cycle starts the next cycle's flags
         seq_next.hs_over_seen = s_hs_over;
         seq_next.ls_over_seen = s_ls_over;
         seq_next.hs_cut = s_hs_over;
      end
      case (seq_reg.state)
         bss_pkg::BSS_OFF: begin
            seq_next.timer = '0;
            seq_next.fcnt = bss_pkg::FCNT_ZERO;
            if (run_ok && s_reg_ok && !s_hot) begin
               seq_next.state = bss_pkg::BSS_SAMPLE;
            end
         end
         bss_pkg::BSS_SAMPLE: begin
            if (seq_reg.timer == T_SAMPLE) begin
               // Higher current means lower resistance; open reads as mid code
               if (s_cur_high) begin
                  seq_next.scp = bss_pkg::SCP_100MV;
               end else if (s_cur_low) begin
                  seq_next.scp = bss_pkg::SCP_280MV;
               end else begin
                  seq_next.scp = bss_pkg::SCP_200MV;
               end
               seq_next.timer = '0;
               seq_next.state = bss_pkg::BSS_PRECOND;
            end
         end
         bss_pkg::BSS_PRECOND: begin
            if (seq_reg.timer == T_PRECOND) begin
               seq_next.timer = '0;
               seq_next.fcnt = bss_pkg::FCNT_ZERO;
               seq_next.state = bss_pkg::BSS_SOFTSTART;
            end
         end
         bss_pkg::BSS_SOFTSTART: begin
            if (i_softstart_done) begin
               seq_next.state = bss_pkg::BSS_RUN;
            end
         end
         bss_pkg::BSS_RUN: begin
            seq_next.timer = '0;
         end
         bss_pkg::BSS_HICCUP: begin
            if (seq_reg.timer == T_HICCUP) begin
               seq_next.timer = '0;
               seq_next.fcnt = bss_pkg::FCNT_ZERO;
               // Threshold stays latched; restart goes through precondition
               seq_next.state = bss_pkg::BSS_PRECOND;
            end
         end
         bss_pkg::BSS_THERMAL: begin
            seq_next.timer = '0;
            if (!s_hot) begin
               seq_next.fcnt = bss_pkg::FCNT_ZERO;
               seq_next.state = bss_pkg::BSS_SOFTSTART;
            end
         end
         default: begin
            seq_next.state = bss_pkg::BSS_OFF;
         end
      endcase
      // Fault on full count while switching
      if (switching && seq_reg.fcnt == bss_pkg::FCNT_FULL) begin
         seq_next.state = bss_pkg::BSS_HICCUP;
         seq_next.timer = '0;
      end
      // Thermal trip overrides running states
      if (s_hot && seq_reg.state != bss_pkg::BSS_OFF) begin
         seq_next.state = bss_pkg::BSS_THERMAL;
      end
      // Lockout or disable returns to shutdown above everything else
      if (!run_ok) begin
         seq_next.state = bss_pkg::BSS_OFF;
      end
      if (!(seq_next.state == bss_pkg::BSS_SOFTSTART || seq_next.state == bss_pkg::BSS_RUN)) begin
         seq_next.hs_over_seen = 1'b0;
         seq_next.ls_over_seen = 1'b0;
         seq_next.hs_cut = 1'b0;
      end
   end

   // State register
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         seq_reg.state <= bss_pkg::BSS_OFF;
         seq_reg.timer <= '0;
         seq_reg.scp <= bss_pkg::SCP_RESET;
         seq_reg.fcnt <= bss_pkg::FCNT_ZERO;
         seq_reg.hs_over_seen <= 1'b0;
         seq_reg.ls_over_seen <= 1'b0;
         seq_reg.hs_cut <= 1'b0;
      end else begin
         seq_reg <= seq_next;
      end
   end

   // Outputs decoded from registered state, synchronised inputs and i_pwm_high
   assign o_regulator_en = run_ok;
   // Hot stops the oscillator at once, one edge before the state catches up; in shutdown the state stays off
   assign o_osc_en = run_ok && !s_hot && (seq_reg.state != bss_pkg::BSS_THERMAL);
   assign o_comp_sample = (seq_reg.state == bss_pkg::BSS_SAMPLE);
   assign o_comp_pull_low = (seq_reg.state == bss_pkg::BSS_PRECOND) ||
                            (seq_reg.state == bss_pkg::BSS_HICCUP);
   assign o_softstart_en = (seq_reg.state == bss_pkg::BSS_SOFTSTART);
   assign o_scp_select = seq_reg.scp;
   assign o_fault_count = seq_reg.fcnt;
   assign o_fault = (seq_reg.state == bss_pkg::BSS_HICCUP);
   // Gates off whenever not switching or locked out; high side cut on overcurrent
   assign o_high_side_gate_drive = switching && run_ok && i_pwm_high &&
                                   !seq_reg.hs_cut;
   assign o_low_side_gate_drive = switching && run_ok && !i_pwm_high;
   // Power ok pull-down active unless running in window and cool; run_ok rather than
   // supply alone, so a disable pulls power ok low in the edge before shutdown
   assign o_power_ok_output_oe_b = (seq_reg.state == bss_pkg::BSS_RUN) && s_fb_ok &&
                                   run_ok && !s_hot;
endmodule : bss_sequencer

// [testbench/bss_seq_monitor.sv]
/* Port checker for the buck sequencer.
   Assumes it is bound to bss_sequencer and gets its phase counts. */
`timescale 1ns/1ps
module bss_seq_monitor #(
   parameter int unsigned SAMPLE_CYC = 20,
   parameter int unsigned PRECOND_CYC = 20,
   parameter int unsigned HICCUP_CYC = 50
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_supply_ok,
   input wire logic i_enable_oe_b,
   input wire logic i_enable_level,
   input wire logic i_over_temp,
   input wire logic i_hs_over,
   input wire logic o_regulator_en,
   input wire logic o_osc_en,
   input wire logic o_comp_sample,
   input wire logic o_comp_pull_low,
   input wire logic o_softstart_en,
   input wire logic o_high_side_gate_drive,
   input wire logic o_low_side_gate_drive,
   input wire logic o_power_ok_output_oe_b,
   input wire logic [2:0] o_fault_count,
   input wire logic o_fault
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   logic [2:0] ph_reg; // Phase outputs seen at the last edge
   logic [15:0] run_reg; // Edges spent in the current phase; sized for short counts only
   // One run counter serves all timed phases, since they never overlap
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ph_reg <= 3'h0;
         run_reg <= 16'h0;
      end else begin
         ph_reg <= {o_comp_sample, o_comp_pull_low, o_fault};
         run_reg <= (ph_reg == {o_comp_sample, o_comp_pull_low, o_fault}) ? run_reg + 16'h1 : 16'h1;
      end
   end
   property p_input_undervoltage_lockout_off;
      !i_supply_ok [*3] |-> !o_high_side_gate_drive && !o_low_side_gate_drive && !o_regulator_en;
   endproperty
   a_input_undervoltage_lockout_off: assert property (p_input_undervoltage_lockout_off) else $error("gate drive during lockout");
   property p_disable;
      (!i_enable_oe_b && !i_enable_level) [*3] |-> !o_regulator_en && !o_osc_en;
   endproperty
   a_disable: assert property (p_disable) else $error("active while disabled");
   property p_sample_len;
      $fell(o_comp_sample) && o_comp_pull_low |-> run_reg == 16'(SAMPLE_CYC);
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sample phase length");
   property p_precond_len;
      $fell(o_comp_pull_low) && o_softstart_en |-> run_reg == 16'(PRECOND_CYC);
   endproperty
   a_precond_len: assert property (p_precond_len) else $error("precondition length");
   property p_full_trip;
      o_fault_count == 3'h7 && o_osc_en && !o_comp_sample && !o_comp_pull_low
         |=> (o_fault && !o_high_side_gate_drive && !o_low_side_gate_drive) || !o_osc_en;
   endproperty
   a_full_trip: assert property (p_full_trip) else $error("no fault at full count");
   property p_hiccup_len;
      $fell(o_fault) && o_comp_pull_low |-> run_reg == 16'(HICCUP_CYC);
   endproperty
   a_hiccup_len: assert property (p_hiccup_len) else $error("hiccup wait length");
   property p_pgood_low;
      o_softstart_en || o_fault || !o_osc_en |-> !o_power_ok_output_oe_b;
   endproperty
   a_pgood_low: assert property (p_pgood_low) else $error("power ok released");
   property p_thermal;
      (i_over_temp && o_regulator_en) [*4]
         |-> !o_osc_en && !o_high_side_gate_drive && !o_low_side_gate_drive;
   endproperty
   a_thermal: assert property (p_thermal) else $error("running while hot");
   // Two sync edges plus the cut flag edge: the high side must be off by the third
   property p_hs_cut;
      $past(i_hs_over, 3) |-> !o_high_side_gate_drive;
   endproperty
   a_hs_cut: assert property (p_hs_cut) else $error("high side not cut on overcurrent");
   property p_count_clear;
      $rose(o_softstart_en) |-> o_fault_count == 3'h0;
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("counter not cleared");
endmodule : bss_seq_monitor
bind bss_sequencer bss_seq_monitor #(
   .SAMPLE_CYC(SAMPLE_CYC),
   .PRECOND_CYC(PRECOND_CYC),
   .HICCUP_CYC(HICCUP_CYC)
) u_mon (
   .i_clock(i_clock),
   .i_rst_b(i_rst_b),
   .i_supply_ok(i_supply_ok),
   .i_enable_oe_b(i_enable_oe_b),
   .i_enable_level(i_enable_level),
   .i_over_temp(i_over_temp),
   .i_hs_over(i_hs_over),
   .o_regulator_en(o_regulator_en),
   .o_osc_en(o_osc_en),
   .o_comp_sample(o_comp_sample),
   .o_comp_pull_low(o_comp_pull_low),
   .o_softstart_en(o_softstart_en),
   .o_high_side_gate_drive(o_high_side_gate_drive),
   .o_low_side_gate_drive(o_low_side_gate_drive),
   .o_power_ok_output_oe_b(o_power_ok_output_oe_b),
   .o_fault_count(o_fault_count),
   .o_fault(o_fault)
);

// [testbench/bss_far_side.sv]
/* Model of the power stage and modulator around the sequencer.
   Assumes the bench clock; outputs change on the falling edge. */
`timescale 1ns/1ps
module bss_far_side (
   input wire logic i_clock,
   input wire logic i_short, // Bench commands a shorted output
   input wire logic i_hs_on,
   input wire logic i_ls_on,
   input wire logic i_ss_on,
   output logic o_cycle_start,
   output logic o_pwm_high,
   output logic o_hs_over,
   output logic o_ls_over,
   output logic o_ss_done
);
   logic [3:0] ph_reg = 4'h0; // Position in an eight-cycle switching period
   logic [3:0] ss_reg = 4'h0; // Soft-start ramp age
   initial {o_cycle_start, o_pwm_high, o_hs_over, o_ls_over, o_ss_done} = 5'h0;
   // A drop is only sensed across a switch that is on
   always @(negedge i_clock) begin
      ph_reg <= ph_reg + 4'h1;
      ss_reg <= i_ss_on ? ss_reg + 4'h1 : 4'h0;
      o_cycle_start <= ph_reg[2:0] == 3'h7;
      o_pwm_high <= ph_reg[2:0] < 3'h4;
      o_hs_over <= i_short & i_hs_on;
      o_ls_over <= i_short & i_ls_on;
      o_ss_done <= i_ss_on && (ss_reg > 4'h9); // Ramp idle reads not done
   end
endmodule : bss_far_side

// [testbench/tb_top.sv]
/* Bench for the buck sequencer: start per threshold, faults, power ok, heat.
   Assumes bss_far_side stands in for the power stage. */
`timescale 1ns/1ps
module tb_top;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_supply_ok = 1'b1;
   logic i_enable_oe_b = 1'b0; // Enable pin driven low at first
   logic i_enable_level = 1'b0;
   logic i_regulator_ok = 1'b1;
   logic i_over_temp = 1'b0;
   logic i_comp_cur_high = 1'b0;
   logic i_comp_cur_low = 1'b0;
   logic i_fb_in_window = 1'b1;
   logic short_on = 1'b0; // Far side shorted
   logic i_cycle_start, i_pwm_high, i_hs_over, i_ls_over, i_softstart_done;
   logic o_regulator_en, o_osc_en, o_comp_sample, o_comp_pull_low, o_softstart_en, o_fault;
   logic o_high_side_gate_drive, o_low_side_gate_drive, o_power_ok_output_oe_b;
   logic [1:0] o_scp_select;
   logic [2:0] o_fault_count;
   int miscompares = 0;
   int total_checks = 0;
   bss_sequencer #(.SAMPLE_CYC(20), .PRECOND_CYC(20), .HICCUP_CYC(50)) dut (.*);
   bss_far_side u_far (.i_clock(i_clock), .i_short(short_on), .i_hs_on(o_high_side_gate_drive),
      .i_ls_on(o_low_side_gate_drive), .i_ss_on(o_softstart_en), .o_cycle_start(i_cycle_start),
      .o_pwm_high(i_pwm_high), .o_hs_over(i_hs_over), .o_ls_over(i_ls_over),
      .o_ss_done(i_softstart_done));
   initial forever #4 i_clock = ~i_clock;
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      total_checks++;
      if (got !== ex) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge i_clock);
   endtask : tick
   // Counts falling edges spent in one phase, bounded so a stuck phase cannot hang
   task automatic hold(input logic [2:0] v, output int n);
      n = 0;
      while ({o_comp_sample, o_comp_pull_low, o_fault} === v && n < 999) begin
         tick(1);
         n++;
      end
   endtask : hold
   task automatic t_start(input logic flt, input logic hi, input logic lo, input logic [1:0] c);
      int n;
      i_comp_cur_high = hi;
      i_comp_cur_low = lo;
      i_enable_oe_b = 1'b0;
      i_enable_level = 1'b0;
      tick(6);
      chk("off", 8'h0, {o_regulator_en, o_osc_en, o_comp_sample});
      i_regulator_ok = 1'b0; // Regulator not up yet: sampling must wait
      i_enable_oe_b = flt;
      i_enable_level = ~flt;
      tick(6);
      chk("wait regulator", 8'h0, {o_comp_sample, o_comp_pull_low});
      i_regulator_ok = 1'b1;
      hold(3'h0, n);
      hold(3'h4, n);
      chk("sample len", 8'd20, 8'(n));
      chk("threshold", 8'(c), 8'(o_scp_select));
      hold(3'h2, n);
      chk("precond len", 8'd20, 8'(n));
      chk("soft start", 8'h2, {o_softstart_en, o_power_ok_output_oe_b});
   endtask : t_start
   task automatic t_run();
      for (int i = 0; i < 99 && o_softstart_en !== 1'b0; i++) tick(1);
      tick(4);
      chk("pgood", 8'h1, 8'(o_power_ok_output_oe_b));
      i_fb_in_window = 1'b0;
      tick(4);
      chk("pgood fb", 8'h0, 8'(o_power_ok_output_oe_b));
      i_fb_in_window = 1'b1;
      chk("count floor", 8'h0, 8'(o_fault_count));
      short_on = 1'b1;
      tick(16);
      short_on = 1'b0;
      chk("count up", 8'h1, 8'(o_fault_count != 3'h0));
      tick(48);
      chk("count down", 8'h0, 8'(o_fault_count));
   endtask : t_run
   task automatic t_short();
      int n;
      short_on = 1'b1;
      for (int i = 0; i < 400 && o_fault !== 1'b1; i++) tick(1);
      chk("full", 8'h7, 8'(o_fault_count));
      chk("gates", 8'h0, {o_high_side_gate_drive, o_low_side_gate_drive});
      hold(3'h3, n);
      chk("hiccup len", 8'd50, 8'(n));
      for (int i = 0; i < 99 && o_softstart_en !== 1'b1; i++) tick(1);
      chk("cleared", 8'h0, 8'(o_fault_count));
      for (int i = 0; i < 400 && o_fault !== 1'b1; i++) tick(1);
      chk("retry", 8'h1, 8'(o_fault));
      short_on = 1'b0;
   endtask : t_short
   task automatic t_heat();
      for (int i = 0; i < 400 && o_softstart_en !== 1'b1; i++) tick(1);
      i_over_temp = 1'b1;
      tick(6);
      chk("hot", 8'h0, {o_osc_en, o_high_side_gate_drive, o_low_side_gate_drive});
      i_over_temp = 1'b0;
      tick(6);
      chk("cool", 8'h1, {o_comp_pull_low, o_softstart_en});
      i_supply_ok = 1'b0;
      tick(6);
      chk("input_undervoltage_lockout", 8'h0, {o_regulator_en, o_high_side_gate_drive, o_low_side_gate_drive});
   endtask : t_heat
   task automatic wrap_up();
      if (miscompares == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      wrap_up();
   end
   initial begin
      tick(20);
      i_rst_b = 1'b1;
      t_start(1'b1, 1'b1, 1'b0, bss_pkg::SCP_100MV);
      t_start(1'b0, 1'b0, 1'b1, bss_pkg::SCP_280MV);
      t_start(1'b0, 1'b0, 1'b0, bss_pkg::SCP_200MV);
      t_run();
      t_short();
      t_heat();
      wrap_up();
   end
endmodule : tb_top
